/* common/buck_sup_params.svh */
// constants for the step-down supervisor: sizes, timing, register map
// assumes a 40 MHz system clock; included by the package and the checker
`ifndef BUCK_SUP_PARAMS_SVH
`define BUCK_SUP_PARAMS_SVH
// ********************
// sizes
// ********************
`define NUM_BUCK 4
`define NUM_LDO 4
`define CODE_W 7
`define SYNC_W 36
`define RAMP_CNT_W 9
`define PERSIST_CNT_W 13
`define BLANK_CNT_W 17
// ********************
// timing
// ********************
`define CLK_MHZ 40
`define SHORT_PERSIST_US 160
`define BLANK_MS 2
`define RAMP_SLOPE_UV_PER_US 2500
`define STEP_UV_LO 10000
`define STEP_UV_HI 20000
`define PERSIST_CYC (`SHORT_PERSIST_US * `CLK_MHZ)
`define BLANK_CYC (`BLANK_MS * 1000 * `CLK_MHZ)
`define STEP_CYC_LO ((`STEP_UV_LO * `CLK_MHZ) / `RAMP_SLOPE_UV_PER_US)
`define STEP_CYC_HI ((`STEP_UV_HI * `CLK_MHZ) / `RAMP_SLOPE_UV_PER_US)
// ********************
// register map (byte offsets)
// ********************
`define OFS_CTRL 8'h00
`define OFS_MONITOR 8'h04
`define OFS_MASK_A 8'h08
`define OFS_MASK_B 8'h0c
`define OFS_BUCK_SHORT 8'h10
`define OFS_LINEAR_SHORT 8'h14
`define OFS_THERMAL 8'h18
`define OFS_STATUS 8'h1c
`define OFS_LEVEL_FIRST 8'h20
`define OFS_LEVEL_LAST 8'h3c
`define LVL_IDX_HI 4
`define LVL_IDX_LO 3
`define LVL_SEL_BIT 2
// ********************
// fields and reset values
// ********************
`define CTRL_SINK 0
`define CTRL_THERM 1
`define CTRL_CMPMODE 2
`define CTRL_PHASE_HI 4
`define CTRL_PHASE_LO 3
`define CTRL_IRQ_MASK 5
`define CTRL_RESET 6'h03
`define MASK_A_RESET 4'he
`define MASK_B_TYPE 0
`define PRIM_RANGE 7
`define ALT_CMD 7
`define ALT_RF 8
`define ALT_MAP_HI 10
`define ALT_MAP_LO 9
`define MAP_NONE 2'h0
`define MAP_SLEEP 2'h1
`define MAP_EN1 2'h2
`define MAP_EN2 2'h3
`define MON_B1 0
`define MON_B2 1
`define MON_PAIRED 2
`define MON_B3 3
`define RAIL_B2 1
`define RAIL_FOURTH 3
`define ADC_CURRENT_CHANNEL 3'h4
`endif

/* common/buck_sup_pkg.sv */
// state types for the step-down supervisor and its short filter
// assumes buck_sup_params.svh is on the include path
`include "buck_sup_params.svh"
package buck_sup_pkg;
   // ********************
   // short persistence filter state
   // ********************
   typedef struct packed {
      logic [`PERSIST_CNT_W-1:0] cnt;
      logic hit;
   } persist_state_t;
   // ********************
   // supervisor state
   // ********************
   typedef struct packed {
      logic [`SYNC_W-1:0] s1;
      logic [`SYNC_W-1:0] s2;
      logic waitreq;
      logic [31:0] rdata;
      logic [5:0] ctrl;
      logic [3:0] mon;
      logic [3:0] mask_a;
      logic [4:0] mask_b;
      logic [`NUM_BUCK-1:0][7:0] prim;
      logic [`NUM_BUCK-1:0][10:0] alt;
      logic [`NUM_BUCK-1:0][`CODE_W-1:0] cur;
      logic [`NUM_BUCK-1:0][`RAMP_CNT_W-1:0] rcnt;
      logic [`NUM_BUCK-1:0] ramping;
      logic [`NUM_BUCK-1:0] buck_on;
      logic [`NUM_BUCK-1:0] bshort;
      logic [`NUM_LDO-1:0] lshort;
      logic [1:0] therm;
      logic [`NUM_BUCK+`NUM_LDO-1:0] prev_en;
      logic [`BLANK_CNT_W-1:0] blank_cnt;
      logic blanked;
      logic supply_ok;
      logic irq;
      logic adc_route;
      logic [3:0] ilmon_sel;
   } sup_state_t;
endpackage

/* hdl/short_persist_filter.sv */
// persistence filter: flags a short only after it stands unbroken
// assumes i_short is already synchronised to i_clk_sys
`timescale 1ns/1ps
module short_persist_filter #(
   parameter int PERSIST_CYC = `PERSIST_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // short detect in, persisted level out
   input wire logic i_short,
   output logic o_persisted
);
   buck_sup_pkg::persist_state_t state;
   buck_sup_pkg::persist_state_t next_state;

   // ********************
   // counter
   // ********************
   // any gap in the short restarts the count from zero
   always_comb begin
      next_state = state;
      if (!i_short) begin
         next_state.cnt = '0;
         next_state.hit = 1'b0;
      end else if (state.cnt == `PERSIST_CNT_W'(PERSIST_CYC - 1)) begin
         next_state.hit = 1'b1;
      end else begin
         next_state.cnt = state.cnt + `PERSIST_CNT_W'(1);
      end
   end

   // state register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_persisted = state.hit;
endmodule

/* hdl/buck_supervisor_dvs_ctrl.sv */
// supervision and level control for four step-down converters and four LDOs
// assumes analog comparators, converters and the ADC sit outside; all their
// signals and pins arrive asynchronous and are synchronised here
`timescale 1ns/1ps
module buck_supervisor_dvs_ctrl #(
   parameter int PERSIST_CYC = `PERSIST_CYC,
   parameter int BLANK_CYC = `BLANK_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // converter and ldo status from analog
   input wire logic [`NUM_BUCK-1:0] i_buck_enable,
   input wire logic [`NUM_LDO-1:0] i_ldo_enable,
   input wire logic [`NUM_BUCK-1:0] i_buck_short_det,
   input wire logic [`NUM_LDO-1:0] i_ldo_short_det,
   input wire logic [`NUM_BUCK-1:0] i_buck_volt_ok,
   input wire logic [`NUM_BUCK-1:0] i_buck_curr_ok,
   input wire logic [`NUM_BUCK-1:0] i_buck_forced_pwm,
   input wire logic [1:0] i_thermal_raw,
   input wire logic i_adc_current_ok,
   input wire logic i_dual_phase,
   input wire logic i_device_enable,
   // control pins
   input wire logic i_sleep_request_pin,
   input wire logic i_enable_pin_one,
   input wire logic i_enable_pin_two,
   // converter control out
   output logic o_sink_limit_enable,
   output logic o_buck_thermal_enable,
   output logic [1:0] o_phase_mode_force,
   output logic [`NUM_BUCK-1:0] o_buck_on,
   output logic [`NUM_BUCK*`CODE_W-1:0] o_buck_level_code,
   output logic [`NUM_BUCK-1:0] o_buck_range,
   output logic [`NUM_LDO-1:0] o_linear_force_off,
   // monitoring out
   output logic o_adc_ch4_route,
   output logic [3:0] o_load_current_select,
   output logic o_supply_ok,
   output logic o_short_irq
);
   buck_sup_pkg::sup_state_t state;
   buck_sup_pkg::sup_state_t next_state;

   logic [`NUM_BUCK-1:0] sy_buck_en;
   logic [`NUM_LDO-1:0] sy_ldo_en;
   logic [`NUM_BUCK-1:0] sy_bshort;
   logic [`NUM_LDO-1:0] sy_lshort;
   logic [`NUM_BUCK-1:0] sy_vok;
   logic [`NUM_BUCK-1:0] sy_iok;
   logic [`NUM_BUCK-1:0] sy_pwm;
   logic [1:0] sy_therm;
   logic sy_adc_ok;
   logic sy_pin_sleep;
   logic sy_pin_en1;
   logic sy_pin_en2;
   logic sy_dual;
   logic sy_dev_en;
   logic [`NUM_BUCK+`NUM_LDO-1:0] persisted;
   wire logic [`NUM_BUCK+`NUM_LDO-1:0] raw_short = {sy_lshort, sy_bshort};

   // ********************
   // helpers
   // ********************
   // byte-lane merge of a write into the current register value
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            res[k*8 +: 8] = new_v[k*8 +: 8];
         end
      end
      return res;
   endfunction

   // level block hit: primary and alternate words for each converter
   function automatic logic level_hit(input logic [7:0] addr);
      return (addr >= `OFS_LEVEL_FIRST) && (addr <= `OFS_LEVEL_LAST)
         && (addr[1:0] == 2'h0);
   endfunction

   // register readback, shared by the read path and the write merge
   function automatic logic [31:0] reg_read(input logic [7:0] addr);
      logic [1:0] idx;
      idx = addr[`LVL_IDX_HI:`LVL_IDX_LO];
      case (addr)
         `OFS_CTRL: return {26'h0, state.ctrl};
         `OFS_MONITOR: return {28'h0, state.mon};
         `OFS_MASK_A: return {28'h0, state.mask_a};
         `OFS_MASK_B: return {27'h0, state.mask_b};
         `OFS_BUCK_SHORT: return {28'h0, state.bshort};
         `OFS_LINEAR_SHORT: return {28'h0, state.lshort};
         `OFS_THERMAL: return {30'h0, state.therm};
         `OFS_STATUS: return {22'h0, state.blanked, state.supply_ok,
            state.ramping, state.buck_on};
         default: begin
            if (!level_hit(addr)) begin
               return 32'h0;
            end else if (addr[`LVL_SEL_BIT]) begin
               return {21'h0, state.alt[idx]};
            end else begin
               return {24'h0, state.prim[idx]};
            end
         end
      endcase
   endfunction

   // lowest set monitor request wins; only one rail measured at a time
   function automatic logic [3:0] pick_lowest(input logic [3:0] req);
      logic [3:0] res;
      res = 4'h0;
      for (int k = 3; k >= 0; k--) begin
         if (req[k]) begin
            res = 4'h0;
            res[k] = 1'b1;
         end
      end
      return res;
   endfunction

   // ********************
   // synchronised inputs
   // ********************
   // unpack of the second sync stage only
   assign {sy_buck_en, sy_ldo_en, sy_bshort, sy_lshort, sy_vok, sy_iok, sy_pwm,
      sy_therm, sy_adc_ok, sy_pin_sleep, sy_pin_en1, sy_pin_en2, sy_dual,
      sy_dev_en} = state.s2;

   // one persistence filter per rail, ldos in the upper half
   generate
      for (genvar g = 0; g < `NUM_BUCK + `NUM_LDO; g++) begin : g_filt
         short_persist_filter #(
            .PERSIST_CYC(PERSIST_CYC)
         ) u_filt (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(i_rst_n),
            .i_short(raw_short[g]),
            .o_persisted(persisted[g])
         );
      end
   endgenerate

   // ********************
   // next state
   // ********************
   always_comb begin
      logic wr_go;
      logic rd_go;
      logic [31:0] merged;
      logic [1:0] lidx;
      logic [`NUM_BUCK-1:0] bset;
      logic [`NUM_LDO-1:0] lset;
      logic [`NUM_BUCK+`NUM_LDO-1:0] rails_en;
      logic [`NUM_BUCK-1:0][`CODE_W-1:0] tgt;
      logic [`RAMP_CNT_W-1:0] step_cyc;
      logic pin;
      logic use_prim;
      logic [3:0] mon_pick;
      logic [1:0] mon_rail;
      logic v_pass;
      logic i_pass;
      logic ok;
      next_state = state;
      wr_go = i_avs_write && !state.waitreq;
      rd_go = i_avs_read && !state.waitreq;
      merged = be_merge(reg_read(i_avs_address), i_avs_writedata, i_avs_byteenable);
      lidx = i_avs_address[`LVL_IDX_HI:`LVL_IDX_LO];
      rails_en = {sy_ldo_en, sy_buck_en};
      pin = 1'b0;
      use_prim = 1'b1;
      step_cyc = '0;
      v_pass = 1'b0;
      i_pass = 1'b0;
      ok = 1'b1;
      tgt = '0;

      // two-stage synchroniser for all asynchronous inputs
      next_state.s1 = {i_buck_enable, i_ldo_enable, i_buck_short_det,
         i_ldo_short_det, i_buck_volt_ok, i_buck_curr_ok, i_buck_forced_pwm,
         i_thermal_raw, i_adc_current_ok, i_sleep_request_pin, i_enable_pin_one,
         i_enable_pin_two, i_dual_phase, i_device_enable};
      next_state.s2 = state.s1;

      // bus handshake: one wait cycle, read data loaded as waitrequest falls
      next_state.waitreq = 1'b1;
      if ((i_avs_read || i_avs_write) && state.waitreq) begin
         next_state.waitreq = 1'b0;
         next_state.rdata = i_avs_read ? reg_read(i_avs_address) : 32'h0;
      end

      // register writes take effect at the accepting edge only
      if (wr_go) begin
         case (i_avs_address)
            `OFS_CTRL: next_state.ctrl = merged[5:0];
            `OFS_MONITOR: next_state.mon = merged[3:0];
            `OFS_MASK_A: next_state.mask_a = merged[3:0];
            `OFS_MASK_B: next_state.mask_b = merged[4:0];
            default: begin
               if (level_hit(i_avs_address) && i_avs_address[`LVL_SEL_BIT]) begin
                  next_state.alt[lidx] = merged[10:0];
               end else if (level_hit(i_avs_address)) begin
                  next_state.prim[lidx] = merged[7:0];
               end
            end
         endcase
      end

      // startup blanking; restarts on any rail turning on
      next_state.prev_en = rails_en;
      if (!sy_dev_en || |(rails_en & ~state.prev_en)) begin
         next_state.blank_cnt = '0;
         next_state.blanked = 1'b1;
      end else if (state.blanked) begin
         if (state.blank_cnt == `BLANK_CNT_W'(BLANK_CYC - 1)) begin
            next_state.blanked = 1'b0;
         end else begin
            next_state.blank_cnt = state.blank_cnt + `BLANK_CNT_W'(1);
         end
      end

      // short flags: set wins over a clear in the same cycle
      bset = persisted[`NUM_BUCK-1:0] & sy_buck_en & {`NUM_BUCK{!state.blanked}};
      lset = persisted[`NUM_BUCK+`NUM_LDO-1:`NUM_BUCK] & sy_ldo_en
         & {`NUM_LDO{!state.blanked}};
      next_state.bshort = state.bshort;
      next_state.lshort = state.lshort;
      if (rd_go && i_avs_address == `OFS_BUCK_SHORT) begin
         next_state.bshort = state.bshort & ~state.rdata[3:0];
      end
      if (rd_go && i_avs_address == `OFS_LINEAR_SHORT) begin
         next_state.lshort = state.lshort & ~state.rdata[3:0];
      end
      next_state.bshort = next_state.bshort | bset;
      next_state.lshort = next_state.lshort | lset;
      next_state.irq = (|next_state.bshort || |next_state.lshort)
         && !state.ctrl[`CTRL_IRQ_MASK];

      // thermal status only tracked while monitoring is on
      next_state.therm = state.ctrl[`CTRL_THERM] ? sy_therm : 2'h0;

      // level selection and ramp per converter
      for (int i = 0; i < `NUM_BUCK; i++) begin
         case (state.alt[i][`ALT_MAP_HI:`ALT_MAP_LO])
            `MAP_SLEEP: pin = sy_pin_sleep;
            `MAP_EN1: pin = sy_pin_en1;
            `MAP_EN2: pin = sy_pin_en2;
            default: pin = 1'b1;
         endcase
         if (state.alt[i][`ALT_RF]) begin
            use_prim = pin;
         end else begin
            use_prim = !state.alt[i][`ALT_CMD];
         end
         tgt[i] = use_prim ? state.prim[i][`CODE_W-1:0] : state.alt[i][`CODE_W-1:0];
         step_cyc = state.prim[i][`PRIM_RANGE] ? `RAMP_CNT_W'(`STEP_CYC_HI)
            : `RAMP_CNT_W'(`STEP_CYC_LO);
         // the fourth converter and turn-on or turn-off jump straight
         if (i == `RAIL_FOURTH || tgt[i] == '0 || state.cur[i] == '0) begin
            next_state.cur[i] = tgt[i];
            next_state.rcnt[i] = '0;
         end else if (state.cur[i] != tgt[i]) begin
            if (state.rcnt[i] >= step_cyc - `RAMP_CNT_W'(1)) begin
               next_state.rcnt[i] = '0;
               next_state.cur[i] = (state.cur[i] < tgt[i])
                  ? state.cur[i] + `CODE_W'(1) : state.cur[i] - `CODE_W'(1);
            end else begin
               next_state.rcnt[i] = state.rcnt[i] + `RAMP_CNT_W'(1);
            end
         end else begin
            next_state.rcnt[i] = '0;
         end
         next_state.ramping[i] = next_state.cur[i] != tgt[i];
         // code zero or a latched short keeps the converter off
         next_state.buck_on[i] = sy_buck_en[i] && tgt[i] != '0
            && !next_state.bshort[i];
      end

      // load current monitor selection
      mon_pick = pick_lowest(state.mon);
      mon_rail = mon_pick[`MON_B2] ? 2'h1 : (mon_pick[`MON_B3] ? 2'h2 : 2'h0);
      next_state.adc_route = |mon_pick && sy_pwm[mon_rail];
      next_state.ilmon_sel = next_state.adc_route ? mon_pick : 4'h0;

      // supply-OK combine over unmasked rails
      for (int i = 0; i < `NUM_BUCK; i++) begin
         v_pass = state.mask_b[`MASK_B_TYPE] || sy_vok[i]
            || state.ramping[i];
         i_pass = sy_iok[i] || state.mask_b[i + 1];
         if (state.ctrl[`CTRL_CMPMODE] && state.adc_route && mon_rail == 2'(i)) begin
            i_pass = i_pass && sy_adc_ok;
         end
         if (!(state.mask_a[i] || (sy_dual && i == `RAIL_B2))) begin
            ok = ok && v_pass && i_pass;
         end
      end
      next_state.supply_ok = ok;
   end

   // ********************
   // state register
   // ********************
   // reset values: limits and thermal on, first rail unmasked, primary level
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
         state.waitreq <= 1'b1;
         state.ctrl <= `CTRL_RESET;
         state.mask_a <= `MASK_A_RESET;
         state.blanked <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ********************
   // outputs, all straight from the state register
   // ********************
   assign o_avs_readdata = state.rdata;
   assign o_avs_waitrequest = state.waitreq;
   assign o_sink_limit_enable = state.ctrl[`CTRL_SINK];
   assign o_buck_thermal_enable = state.ctrl[`CTRL_THERM];
   assign o_phase_mode_force = state.ctrl[`CTRL_PHASE_HI:`CTRL_PHASE_LO];
   assign o_buck_on = state.buck_on;
   assign o_buck_level_code = state.cur;
   assign o_linear_force_off = state.lshort;
   assign o_adc_ch4_route = state.adc_route;
   assign o_load_current_select = state.ilmon_sel;
   assign o_supply_ok = state.supply_ok;
   assign o_short_irq = state.irq;

   // range bit of each primary register
   generate
      for (genvar g = 0; g < `NUM_BUCK; g++) begin : g_range
         assign o_buck_range[g] = state.prim[g][`PRIM_RANGE];
      end
   endgenerate
endmodule

/* dv/buck_sup_props.sv */
// checker for the step-down supervisor: bus timing, ldo flags, ramp steps
// assumes it is bound to buck_supervisor_dvs_ctrl and sees only its ports
`timescale 1ns/1ps
`include "buck_sup_params.svh"
module buck_sup_props #(
   parameter int PERSIST_CYC = 8,
   parameter int BLANK_CYC = 20
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // bus
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   // rails
   input wire logic [`NUM_LDO-1:0] i_ldo_short_det,
   input wire logic [`NUM_LDO-1:0] o_linear_force_off,
   input wire logic o_short_irq,
   input wire logic [`NUM_BUCK-1:0] o_buck_on,
   input wire logic [`NUM_BUCK*`CODE_W-1:0] o_buck_level_code,
   input wire logic o_sink_limit_enable,
   input wire logic o_buck_thermal_enable
);
   // ********************
   // helpers
   // ********************
   // edge at which a read of the ldo flags completes and clears them
   wire logic ldo_rd = i_avs_read && !o_avs_waitrequest && i_avs_address == `OFS_LINEAR_SHORT;
   wire logic [6:0] lvl0 = o_buck_level_code[6:0];
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // ********************
   // properties
   // ********************
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_reset_ctrl: assert property ($rose(i_rst_n) |-> o_sink_limit_enable &&
      o_buck_thermal_enable) else $error("control enables not set after reset");
   a_irq_cause: assert property ($rose(o_short_irq) |-> o_buck_on != $past(o_buck_on) ||
      o_linear_force_off != $past(o_linear_force_off)) else $error("irq without a short");
   a_ldo_hold: assert property (o_linear_force_off[0] && !ldo_rd |=> o_linear_force_off[0])
      else $error("ldo flag dropped without a read");
   a_ldo_clear: assert property (o_linear_force_off[0] && ldo_rd && !i_ldo_short_det[0] &&
      !$past(i_ldo_short_det[0], 2) && !$past(i_ldo_short_det[0], 4) |=> !o_linear_force_off[0])
      else $error("ldo flag not cleared by read");
   a_ldo_persist: assert property ($rose(o_linear_force_off[0]) |->
      $past(i_ldo_short_det[0], 4) && $past(i_ldo_short_det[0], 8)) else $error("short too brief");
   a_ramp_unit: assert property ($changed(lvl0) && o_buck_on[0] && $past(o_buck_on[0], 2)
      |-> lvl0 == $past(lvl0) + 7'h1 || lvl0 + 7'h1 == $past(lvl0)) else $error("ramp step not one");
   a_ramp_pace: assert property ($changed(lvl0) && o_buck_on[0] && $past(o_buck_on[0], 2)
      |=> $stable(lvl0) [*8]) else $error("ramp steps too fast");
endmodule

/* dv/buck_analog_model.sv */
// analog side stand-in: converters that are on report healthy unless a fault is injected
// assumes the bench drives the fault masks after clock edges
`timescale 1ns/1ps
module buck_analog_model (
   // converter state and injected faults
   input wire logic [3:0] i_buck_on,
   input wire logic [3:0] i_volt_bad,
   input wire logic [3:0] i_curr_bad,
   // comparator results
   output logic [3:0] o_volt_ok,
   output logic [3:0] o_curr_ok
);
   // an off converter fails its voltage check, as a real rail would
   assign o_volt_ok = i_buck_on & ~i_volt_bad;
   assign o_curr_ok = ~i_curr_bad;
endmodule

/* dv/buck_supervisor_dvs_ctrl_test.sv */
// bench for the step-down supervisor: register calls with expected values
// assumes the analog model on the comparator inputs and short counts of 8 and 20
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module buck_supervisor_dvs_ctrl_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] buck_en = 4'h0, ldo_en = 4'h0, bshort = 4'h0, lshort = 4'h0;
   logic [3:0] vbad = 4'h0, cbad = 4'h0, pwm = 4'h0;
   logic [1:0] therm = 2'h0;
   logic dual = 1'b0, dev_en = 1'b0, sleep_pin = 1'b0, adc_ok = 1'b1;
   wire [31:0] rdata;
   wire [27:0] code;
   wire [3:0] vok, cok, buck_on, lfo, isel, rng;
   wire [1:0] phase;
   wire wreq, sink, then, route, sok, irq;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] d;
   always #12.5 clk = ~clk;
   buck_supervisor_dvs_ctrl #(.PERSIST_CYC(8), .BLANK_CYC(20)) dut (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_buck_enable(buck_en),
      .i_ldo_enable(ldo_en), .i_buck_short_det(bshort), .i_ldo_short_det(lshort),
      .i_buck_volt_ok(vok), .i_buck_curr_ok(cok), .i_buck_forced_pwm(pwm),
      .i_thermal_raw(therm), .i_adc_current_ok(adc_ok), .i_dual_phase(dual),
      .i_device_enable(dev_en), .i_sleep_request_pin(sleep_pin), .i_enable_pin_one(1'b0),
      .i_enable_pin_two(1'b0), .o_sink_limit_enable(sink), .o_buck_thermal_enable(then),
      .o_phase_mode_force(phase), .o_buck_on(buck_on), .o_buck_level_code(code),
      .o_buck_range(rng), .o_linear_force_off(lfo), .o_adc_ch4_route(route),
      .o_load_current_select(isel), .o_supply_ok(sok), .o_short_irq(irq));
   buck_analog_model analog (.i_buck_on(buck_on), .i_volt_bad(vbad), .i_curr_bad(cbad),
      .o_volt_ok(vok), .o_curr_ok(cok));
   // ********************
   // bus access and closing
   // ********************
   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      // a slave that never answers counts as a mismatch
      if (n >= 20) begin
         fail_count++;
      end
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // two idle edges so registered effects have settled before checks
      repeat (2) @(posedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // watchdog: the sequence needs about 1600 cycles
   initial begin
      #(25 * 20000);
      fail_count++;
      close_out;
   end
   // ********************
   // sequence
   // ********************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(sink, 1'b1)
      `CHK(phase, 2'h0)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(d, 32'h3)
      bus(1'b0, 8'h08, 32'h0);
      `CHK(d, 32'he)
      therm <= 2'h2;
      repeat (5) @(posedge clk);
      bus(1'b0, 8'h18, 32'h0);
      `CHK(d, 32'h2)
      bus(1'b1, 8'h00, 32'h1);
      `CHK(then, 1'b0)
      // rails up with a nonzero primary code
      dev_en <= 1'b1;
      buck_en <= 4'hf;
      ldo_en <= 4'h1;
      for (int i = 0; i < 4; i++) bus(1'b1, 8'(8'h20 + 8 * i), 32'h10);
      repeat (40) @(posedge clk);
      `CHK(buck_on, 4'hf)
      `CHK(rng, 4'h0)
      ldo_en <= 4'h3;
      repeat (3) @(posedge clk);
      bus(1'b0, 8'h1c, 32'h0);
      `CHK(d[9], 1'b1)
      repeat (40) @(posedge clk);
      bus(1'b0, 8'h1c, 32'h0);
      `CHK(d[9], 1'b0)
      // a brief ldo short is filtered, a long one latches
      lshort <= 4'h1;
      repeat (5) @(posedge clk);
      lshort <= 4'h0;
      repeat (20) @(posedge clk);
      `CHK(lfo, 4'h0)
      lshort <= 4'h1;
      repeat (20) @(posedge clk);
      lshort <= 4'h0;
      `CHK(lfo, 4'h1)
      `CHK(irq, 1'b1)
      repeat (6) @(posedge clk);
      bus(1'b0, 8'h14, 32'h0);
      `CHK(d, 32'h1)
      bus(1'b0, 8'h14, 32'h0);
      `CHK(d, 32'h0)
      `CHK(irq, 1'b0)
      // converter short holds the rail off until the flags are read
      bshort <= 4'h4;
      repeat (20) @(posedge clk);
      bshort <= 4'h0;
      repeat (10) @(posedge clk);
      `CHK(buck_on, 4'hb)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(d, 32'h4)
      repeat (6) @(posedge clk);
      `CHK(buck_on, 4'hf)
      bus(1'b1, 8'h00, 32'h21);
      bshort <= 4'h8;
      repeat (20) @(posedge clk);
      bshort <= 4'h0;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b0)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(d, 32'h8)
      bus(1'b1, 8'h00, 32'h1);
      // supply-ok masking and type select
      repeat (8) @(posedge clk);
      `CHK(sok, 1'b1)
      vbad <= 4'h8;
      repeat (6) @(posedge clk);
      `CHK(sok, 1'b1)
      bus(1'b1, 8'h08, 32'h0);
      `CHK(sok, 1'b0)
      bus(1'b1, 8'h0c, 32'h1);
      `CHK(sok, 1'b1)
      bus(1'b1, 8'h0c, 32'h0);
      vbad <= 4'h2;
      dual <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(sok, 1'b1)
      dual <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(sok, 1'b0)
      // level select by command bit, ramp masks the voltage check
      vbad <= 4'h1;
      bus(1'b1, 8'h24, 32'h92);
      bus(1'b0, 8'h1c, 32'h0);
      `CHK(d[4], 1'b1)
      `CHK(sok, 1'b1)
      repeat (400) @(posedge clk);
      `CHK(code[6:0], 7'h12)
      `CHK(sok, 1'b0)
      vbad <= 4'h0;
      bus(1'b1, 8'h24, 32'h312);
      sleep_pin <= 1'b1;
      repeat (400) @(posedge clk);
      `CHK(code[6:0], 7'h10)
      sleep_pin <= 1'b0;
      repeat (400) @(posedge clk);
      `CHK(code[6:0], 7'h12)
      bus(1'b1, 8'h3c, 32'h80);
      repeat (4) @(posedge clk);
      `CHK(buck_on[3], 1'b0)
      bus(1'b0, 8'h40, 32'h0);
      `CHK(d, 32'h0)
      // current monitor routing and phase force
      bus(1'b1, 8'h04, 32'h1);
      pwm <= 4'h1;
      repeat (6) @(posedge clk);
      `CHK(route, 1'b1)
      `CHK(isel, 4'h1)
      // the off fourth rail is masked before compare mode is tried
      bus(1'b1, 8'h08, 32'h8);
      bus(1'b1, 8'h00, 32'h5);
      `CHK(sok, 1'b1)
      adc_ok <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(sok, 1'b0)
      adc_ok <= 1'b1;
      pwm <= 4'h0;
      repeat (6) @(posedge clk);
      `CHK(route, 1'b0)
      bus(1'b1, 8'h00, 32'h19);
      `CHK(phase, 2'h3)
      close_out;
   end
endmodule
bind buck_supervisor_dvs_ctrl buck_sup_props #(.PERSIST_CYC(PERSIST_CYC), .BLANK_CYC(BLANK_CYC))
   u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
   .i_ldo_short_det(i_ldo_short_det), .o_linear_force_off(o_linear_force_off),
   .o_short_irq(o_short_irq), .o_buck_on(o_buck_on), .o_buck_level_code(o_buck_level_code),
   .o_sink_limit_enable(o_sink_limit_enable), .o_buck_thermal_enable(o_buck_thermal_enable));
